/* File: verilog/shs_pkg.sv */
// Constants, register map and state codes of the servo homing sequencer.
// Assumes a single 125 MHz system clock and a plain strobe register port.
// Functional notes
// - Electrical home move stops once displacement done
// - Method 0 off, 1 trigger homing, 2 trigger electrical
// - Method 3 homes at power-on, 4 immediately
// - Method 5 electrical move, 6 take present position
// - Modes 0/1: home switch decelerates and homes
// - Modes 2/3: Z pulse decelerates and homes
// - Modes 4/5: home switch, then first Z
// - Modes 8/9: limit switch, then following Z
// - Mode 6: forward limit decelerates and homes
// - Offset action 0/2 absolute, 1/3 relative
// - Limit hit: 0/1 stop and wait, 2/3 reverse
// - Ramp time is milliseconds for 0 to 1000 RPM
// - Exceeding duration limit raises homing timeout error
package shs_pkg;

	// =====================================================
	// Register port
	localparam int          ADDR_W             = 4;
	localparam int          DATA_W             = 32;
	localparam int          CFG_W              = 16;
	localparam logic [3:0]  REG_ENABLE_METHOD  = 4'h0;
	localparam logic [3:0]  REG_MODE_SELECT    = 4'h1;
	localparam logic [3:0]  REG_OFFSET_LIMIT   = 4'h2;
	localparam logic [3:0]  REG_ACCEL_TIME     = 4'h3;
	localparam logic [3:0]  REG_DURATION_LIMIT = 4'h4;
	localparam logic [3:0]  REG_HOME_OFFSET    = 4'h5;
	localparam logic [3:0]  REG_ABS_POSITION   = 4'h6;
	localparam logic [3:0]  REG_IRQ_STATUS     = 4'h7;
	localparam logic [3:0]  REG_IRQ_MASK       = 4'h8;
	localparam logic [3:0]  REG_SEQ_STATE      = 4'h9;

	// =====================================================
	// Reset values
	localparam logic [15:0] RST_METHOD   = 16'h0000;
	localparam logic [15:0] RST_MODE     = 16'h0000;
	localparam logic [15:0] RST_LIMACT   = 16'h0000;
	localparam logic [15:0] RST_ACCEL    = 16'h03E8;
	localparam logic [15:0] RST_DURATION = 16'h2710;
	localparam logic [31:0] RST_OFFSET   = 32'h0000_0000;

	// =====================================================
	// Enable methods, homing modes, offset/limit action bits
	localparam logic [15:0] METHOD_OFF       = 16'h0000;
	localparam logic [15:0] METHOD_TRIG_HOME = 16'h0001;
	localparam logic [15:0] METHOD_TRIG_ELEC = 16'h0002;
	localparam logic [15:0] METHOD_POWER_ON  = 16'h0003;
	localparam logic [15:0] METHOD_NOW       = 16'h0004;
	localparam logic [15:0] METHOD_ELEC_NOW  = 16'h0005;
	localparam logic [15:0] METHOD_TAKE_POS  = 16'h0006;
	localparam logic [15:0] MODE_MAX         = 16'h0009;
	localparam int          LIMACT_REL_BIT   = 0;
	localparam int          LIMACT_AUTO_BIT  = 1;
	localparam int          RAMP_REF_RPM     = 1000;

	// =====================================================
	// Interrupt status bits
	localparam int STS_HOME_DONE  = 0;
	localparam int STS_ELEC_DONE  = 1;
	localparam int STS_TIMEOUT    = 2;
	localparam int STS_LIMIT_STOP = 3;
	localparam int STS_W          = 4;

	// =====================================================
	// Synchronised pin indexes
	localparam int          IN_W        = 6;
	localparam logic [2:0]  IN_TRIGGER  = 3'h0;
	localparam logic [2:0]  IN_HOME_SW  = 3'h1;
	localparam logic [2:0]  IN_ZPULSE   = 3'h2;
	localparam logic [2:0]  IN_FWD_LIM  = 3'h3;
	localparam logic [2:0]  IN_REV_LIM  = 3'h4;
	localparam logic [2:0]  IN_SERVO_ON = 3'h5;

	// =====================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_IN_NS      = 1000000;
	localparam int CYCLES_PER_MS = MS_IN_NS / CLK_PERIOD_NS;

	typedef enum logic [6:0] {
		S_IDLE    = 7'h01,
		S_FAST    = 7'h02,
		S_BACK    = 7'h04,
		S_CREEP   = 7'h08,
		S_ZWAIT   = 7'h10,
		S_LIMWAIT = 7'h20,
		S_ELEC    = 7'h40
	} shs_state_e;

endpackage

/* File: verilog/shs_sense_if.sv */
// Carrier for synchronised pin levels and their edges.
// Assumes producer and consumer share clk_sys.
`timescale 1ns/1ps
interface shs_sense_if #(parameter int N = 6);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

/* File: verilog/shs_input_sync.sv */
// Two-stage synchroniser and edge detector for the external pins.
// Assumes pins are asynchronous to clk_sys.
`timescale 1ns/1ps
module shs_input_sync #(
	parameter int N = 6
) (
	input  wire logic         clk_sys,
	input  wire logic         reset_n,
	input  wire logic [N-1:0] pinIn,
	shs_sense_if.src          sense
);
	logic [N-1:0] meta;
	logic [N-1:0] stable;
	logic [N-1:0] prev;

	// First stage feeds only the second one
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta   <= '0;
			stable <= '0;
			prev   <= '0;
		end else begin
			meta   <= pinIn;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign sense.level = stable;
	assign sense.rise  = stable & ~prev;
	assign sense.fall  = ~stable & prev;
endmodule

/* File: verilog/shs_ms_timer.sv */
// Millisecond elapsed-time watchdog for one homing run.
// Assumes run stays high for the whole run and drops in idle.
`timescale 1ns/1ps
module shs_ms_timer #(
	parameter int CYC_PER_MS = 125000
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        run,
	input  wire logic [15:0] limitMs,
	output logic             expired
);
	logic [16:0] cycCount;
	logic [16:0] next_cycCount;
	logic [16:0] msCount;
	logic [16:0] next_msCount;
	logic        next_expired;

	always_comb begin
		next_cycCount = '0;
		next_msCount  = '0;
		next_expired  = 1'b0;
		if (run) begin
			next_msCount = msCount;
			if (cycCount == 17'(CYC_PER_MS - 1)) begin
				next_cycCount = '0;
				// Saturate so a stuck run still reports
				if (msCount != 17'h1FFFF) begin
					next_msCount = msCount + 17'h00001;
				end
			end else begin
				next_cycCount = cycCount + 17'h00001;
			end
			next_expired = (msCount > {1'b0, limitMs});
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cycCount <= '0;
			msCount  <= '0;
			expired  <= 1'b0;
		end else begin
			cycCount <= next_cycCount;
			msCount  <= next_msCount;
			expired  <= next_expired;
		end
	end
endmodule

/* File: verilog/shs_homing_sequencer.sv */
// Homing sequencer of a servo drive: start methods, search modes,
// electrical home move, timeout and interrupt status.
// Assumes motion logic on clk_sys follows motorRun/motorReverse/motorFast
// and reports motorStopped and the absolute position.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module shs_homing_sequencer
	import shs_pkg::*;
#(
	parameter int CYC_PER_MS = shs_pkg::CYCLES_PER_MS,
	parameter int POS_W      = 32
) (
	input  wire logic                       clk_sys,
	input  wire logic                       reset_n,
	input  wire logic [shs_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [shs_pkg::DATA_W-1:0] regWrData,
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	output logic      [shs_pkg::DATA_W-1:0] regRdData,
	input  wire logic                       homingTriggerIn,
	input  wire logic                       homeSwitchIn,
	input  wire logic                       zPulseIn,
	input  wire logic                       fwdLimitIn,
	input  wire logic                       revLimitIn,
	input  wire logic                       servoOnIn,
	input  wire logic                       motorStopped,
	input  wire logic [POS_W-1:0]           absolutePositionValue,
	output logic                            motorRun,
	output logic                            motorReverse,
	output logic                            motorFast,
	output logic [15:0]                     homingAccelTime,
	output logic                            posLoad,
	output logic [POS_W-1:0]                posLoadValue,
	output logic                            homeAttained,
	output logic                            elecHomeAttained,
	output logic                            homingTimeoutError,
	output logic                            irq
);
	import shs_pkg::*;

	// =====================================================
	// Mode decoding
	function automatic logic [2:0] decelIndex(input logic [15:0] m);
		logic [2:0] idx;
		idx = IN_HOME_SW;
		if (m == 16'h0002 || m == 16'h0003) begin
			idx = IN_ZPULSE;
		end else if (m == 16'h0006 || m == 16'h0008) begin
			idx = IN_FWD_LIM;
		end else if (m == 16'h0007 || m == 16'h0009) begin
			idx = IN_REV_LIM;
		end
		return idx;
	endfunction

	function automatic logic homeIsZ(input logic [15:0] m);
		return (m == 16'h0004 || m == 16'h0005 || m == 16'h0008 || m == 16'h0009);
	endfunction

	function automatic logic motorMoving(input shs_state_e s);
		return (s != S_IDLE && s != S_LIMWAIT);
	endfunction

	// =====================================================
	// Pins and timer
	shs_sense_if #(.N(IN_W)) sense ();
	logic timerExpired;

	shs_input_sync #(.N(IN_W)) u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pinIn   ({servoOnIn, revLimitIn, fwdLimitIn, zPulseIn, homeSwitchIn, homingTriggerIn}),
		.sense   (sense)
	);

	// =====================================================
	// State
	shs_state_e         state,           next_state;
	logic [15:0]        enableMethod,    next_enableMethod;
	logic [15:0]        modeSelect,      next_modeSelect;
	logic [15:0]        offsetLimit,     next_offsetLimit;
	logic [15:0]        durationLimit,   next_durationLimit;
	logic [15:0]        next_homingAccelTime;
	logic [31:0]        homeOffset,      next_homeOffset;
	logic [STS_W-1:0]   irqStatus,       next_irqStatus;
	logic [STS_W-1:0]   irqMask,         next_irqMask;
	logic               searchRev,       next_searchRev;
	logic               backFast,        next_backFast;
	logic               elecRev,         next_elecRev;
	logic               poweredOnce,     next_poweredOnce;
	logic               next_motorRun,   next_motorReverse, next_motorFast;
	logic               next_posLoad,    next_homeAttained, next_elecHomeAttained;
	logic               next_timeoutErr, next_irq;
	logic [POS_W-1:0]   next_posLoadValue;
	logic [DATA_W-1:0]  next_regRdData;
	logic [STS_W-1:0]   events;
	logic [2:0]         dIdx;
	logic               son, sonRise, trigRise;
	logic               decelLevel, decelRise, decelLeave, limitAhead, atStop;
	logic               startSearch, startElec, finishHome;
	logic signed [POS_W-1:0] posNow, posTarget;

	shs_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.run     (state != S_IDLE),
		.limitMs (durationLimit),
		.expired (timerExpired)
	);

	always_comb begin
		dIdx       = decelIndex(modeSelect);
		son        = sense.level[IN_SERVO_ON];
		sonRise    = sense.rise[IN_SERVO_ON];
		trigRise   = sense.rise[IN_TRIGGER];
		decelLevel = sense.level[dIdx];
		decelRise  = sense.rise[dIdx];
		// Z is a pulse, so its departure is taken as its next rising edge
		decelLeave = (dIdx == IN_ZPULSE) ? sense.rise[IN_ZPULSE] : sense.fall[dIdx];
		limitAhead = (dIdx != IN_FWD_LIM && dIdx != IN_REV_LIM)
		           && (searchRev ? sense.level[IN_REV_LIM] : sense.level[IN_FWD_LIM]);
		atStop     = motorStopped && state == S_IDLE;
		posNow     = POS_W'(absolutePositionValue);
		posTarget  = POS_W'(homeOffset);
		startSearch = state == S_IDLE && son && modeSelect <= MODE_MAX
		           && ((enableMethod == METHOD_TRIG_HOME && trigRise)
		           || (enableMethod == METHOD_POWER_ON && sonRise && !poweredOnce)
		           || (enableMethod == METHOD_NOW));
		startElec  = state == S_IDLE && son
		           && ((enableMethod == METHOD_TRIG_ELEC && trigRise)
		           || enableMethod == METHOD_ELEC_NOW);
	end

	// =====================================================
	// Sequencer and register file, next values
	always_comb begin
		next_state            = state;
		next_enableMethod     = enableMethod;
		next_modeSelect       = modeSelect;
		next_offsetLimit      = offsetLimit;
		next_durationLimit    = durationLimit;
		next_homingAccelTime  = homingAccelTime;
		next_homeOffset       = homeOffset;
		next_irqMask          = irqMask;
		next_searchRev        = searchRev;
		next_backFast         = backFast;
		next_elecRev          = elecRev;
		next_poweredOnce      = poweredOnce | sonRise;
		next_posLoad          = 1'b0;
		next_posLoadValue     = posLoadValue;
		next_homeAttained     = homeAttained;
		next_elecHomeAttained = elecHomeAttained;
		next_timeoutErr       = homingTimeoutError;
		events                = '0;
		finishHome            = 1'b0;

		if (!son && enableMethod != METHOD_TRIG_HOME && enableMethod != METHOD_TRIG_ELEC) begin
			next_timeoutErr = 1'b0;
		end

		case (state)
			S_IDLE: begin
				if (startSearch) begin
					next_searchRev    = modeSelect[0];
					next_backFast     = 1'b0;
					next_homeAttained = 1'b0;
					next_timeoutErr   = 1'b0;
					// Already on the deceleration signal: back off slowly first
					next_state = decelLevel ? S_BACK : S_FAST;
				end else if (startElec) begin
					next_elecRev          = posTarget < posNow;
					next_elecHomeAttained = 1'b0;
					next_timeoutErr       = 1'b0;
					next_state            = S_ELEC;
				end else if (enableMethod == METHOD_TAKE_POS) begin
					next_posLoad      = 1'b1;
					next_posLoadValue = offsetLimit[LIMACT_REL_BIT] ? POS_W'(posNow + posTarget) : posTarget;
					next_homeAttained = 1'b1;
					next_enableMethod = METHOD_OFF;
					events[STS_HOME_DONE] = 1'b1;
				end
			end
			S_FAST: begin
				if (decelRise) begin
					next_state = S_BACK;
				end else if (limitAhead) begin
					events[STS_LIMIT_STOP] = !offsetLimit[LIMACT_AUTO_BIT];
					next_backFast = 1'b1;
					next_state    = offsetLimit[LIMACT_AUTO_BIT] ? S_BACK : S_LIMWAIT;
				end
			end
			S_LIMWAIT: begin
				if (trigRise) begin
					next_state = S_BACK;
				end
			end
			S_BACK: begin
				if (decelLeave) begin
					next_backFast = 1'b0;
					next_state    = S_CREEP;
				end
			end
			S_CREEP: begin
				if (decelRise) begin
					if (homeIsZ(modeSelect)) begin
						next_state = S_ZWAIT;
					end else begin
						finishHome = 1'b1;
					end
				end
			end
			S_ZWAIT: begin
				finishHome = sense.rise[IN_ZPULSE];
			end
			S_ELEC: begin
				if (elecRev ? (posNow <= posTarget) : (posNow >= posTarget)) begin
					next_state            = S_IDLE;
					next_elecHomeAttained = 1'b1;
					events[STS_ELEC_DONE] = 1'b1;
					if (enableMethod == METHOD_ELEC_NOW) begin
						next_enableMethod = METHOD_OFF;
					end
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase

		if (finishHome) begin
			next_state        = S_IDLE;
			next_posLoad      = 1'b1;
			next_posLoadValue = offsetLimit[LIMACT_REL_BIT] ? POS_W'(posNow + posTarget) : posTarget;
			next_homeAttained = 1'b1;
			events[STS_HOME_DONE] = 1'b1;
			if (enableMethod == METHOD_NOW) begin
				next_enableMethod = METHOD_OFF;
			end
		end

		// Losing servo-on or overrunning the time limit aborts any run
		if (state != S_IDLE) begin
			if (timerExpired) begin
				next_state            = S_IDLE;
				next_timeoutErr       = 1'b1;
				events[STS_TIMEOUT]   = 1'b1;
				next_posLoad          = 1'b0;
				if (enableMethod == METHOD_NOW || enableMethod == METHOD_ELEC_NOW) begin
					next_enableMethod = METHOD_OFF;
				end
			end else if (!son) begin
				next_state   = S_IDLE;
				next_posLoad = 1'b0;
			end
		end

		// Software writes come last so they win over hardware clears
		if (regWrite) begin
			if (regAddr == REG_ENABLE_METHOD) begin
				next_enableMethod = regWrData[CFG_W-1:0];
			end else if (regAddr == REG_MODE_SELECT && atStop) begin
				next_modeSelect = regWrData[CFG_W-1:0];
			end else if (regAddr == REG_OFFSET_LIMIT && atStop) begin
				next_offsetLimit = regWrData[CFG_W-1:0];
			end else if (regAddr == REG_ACCEL_TIME && atStop) begin
				next_homingAccelTime = regWrData[CFG_W-1:0];
			end else if (regAddr == REG_DURATION_LIMIT && atStop) begin
				next_durationLimit = regWrData[CFG_W-1:0];
			end else if (regAddr == REG_HOME_OFFSET && atStop) begin
				next_homeOffset = regWrData;
			end else if (regAddr == REG_IRQ_MASK) begin
				next_irqMask = regWrData[STS_W-1:0];
			end
		end

		// Set wins over a write-one-to-clear in the same cycle
		next_irqStatus = irqStatus | events;
		if (regWrite && regAddr == REG_IRQ_STATUS) begin
			next_irqStatus = (irqStatus & ~regWrData[STS_W-1:0]) | events;
		end
		next_irq = |(next_irqStatus & next_irqMask);

		next_motorRun     = motorMoving(next_state);
		next_motorFast    = next_state == S_FAST || next_state == S_ELEC
		                 || (next_state == S_BACK && next_backFast);
		next_motorReverse = (next_state == S_ELEC) ? next_elecRev
		                  : (next_state == S_BACK) ? !next_searchRev : next_searchRev;

		next_regRdData = '0;
		if (regRead) begin
			if (regAddr == REG_ENABLE_METHOD) begin
				next_regRdData = {16'h0000, enableMethod};
			end else if (regAddr == REG_MODE_SELECT) begin
				next_regRdData = {16'h0000, modeSelect};
			end else if (regAddr == REG_OFFSET_LIMIT) begin
				next_regRdData = {16'h0000, offsetLimit};
			end else if (regAddr == REG_ACCEL_TIME) begin
				next_regRdData = {16'h0000, homingAccelTime};
			end else if (regAddr == REG_DURATION_LIMIT) begin
				next_regRdData = {16'h0000, durationLimit};
			end else if (regAddr == REG_HOME_OFFSET) begin
				next_regRdData = homeOffset;
			end else if (regAddr == REG_ABS_POSITION) begin
				next_regRdData = DATA_W'(absolutePositionValue);
			end else if (regAddr == REG_IRQ_STATUS) begin
				next_regRdData = {{(DATA_W-STS_W){1'b0}}, irqStatus};
			end else if (regAddr == REG_IRQ_MASK) begin
				next_regRdData = {{(DATA_W-STS_W){1'b0}}, irqMask};
			end else if (regAddr == REG_SEQ_STATE) begin
				next_regRdData = {22'h000000, homingTimeoutError, elecHomeAttained, homeAttained, state};
			end
		end
	end

	// =====================================================
	// Registers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state              <= S_IDLE;
			enableMethod       <= RST_METHOD;
			modeSelect         <= RST_MODE;
			offsetLimit        <= RST_LIMACT;
			durationLimit      <= RST_DURATION;
			homingAccelTime    <= RST_ACCEL;
			homeOffset         <= RST_OFFSET;
			irqStatus          <= '0;
			irqMask            <= '0;
			searchRev          <= 1'b0;
			backFast           <= 1'b0;
			elecRev            <= 1'b0;
			poweredOnce        <= 1'b0;
			motorRun           <= 1'b0;
			motorReverse       <= 1'b0;
			motorFast          <= 1'b0;
			posLoad            <= 1'b0;
			posLoadValue       <= '0;
			homeAttained       <= 1'b0;
			elecHomeAttained   <= 1'b0;
			homingTimeoutError <= 1'b0;
			irq                <= 1'b0;
			regRdData          <= '0;
		end else begin
			state              <= next_state;
			enableMethod       <= next_enableMethod;
			modeSelect         <= next_modeSelect;
			offsetLimit        <= next_offsetLimit;
			durationLimit      <= next_durationLimit;
			homingAccelTime    <= next_homingAccelTime;
			homeOffset         <= next_homeOffset;
			irqStatus          <= next_irqStatus;
			irqMask            <= next_irqMask;
			searchRev          <= next_searchRev;
			backFast           <= next_backFast;
			elecRev            <= next_elecRev;
			poweredOnce        <= next_poweredOnce;
			motorRun           <= next_motorRun;
			motorReverse       <= next_motorReverse;
			motorFast          <= next_motorFast;
			posLoad            <= next_posLoad;
			posLoadValue       <= next_posLoadValue;
			homeAttained       <= next_homeAttained;
			elecHomeAttained   <= next_elecHomeAttained;
			homingTimeoutError <= next_timeoutErr;
			irq                <= next_irq;
			regRdData          <= next_regRdData;
		end
	end
endmodule

/* File: verif/shs_homing_sva.sv */
// Checker of the homing sequencer, top ports only.
// Assumes one clock domain and an active-low reset.
`timescale 1ns/1ps
module shs_homing_sva
	import shs_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic [3:0]  regAddr,
	input wire logic [31:0] regWrData,
	input wire logic        regWrite,
	input wire logic        servoOnIn,
	input wire logic        motorStopped,
	input wire logic        motorRun,
	input wire logic [15:0] homingAccelTime,
	input wire logic        posLoad,
	input wire logic        homeAttained,
	input wire logic        elecHomeAttained,
	input wire logic        homingTimeoutError
);
	// ==========
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_home_stop; $rose(homeAttained) |-> !motorRun; endproperty
	a_home_stop: assert property (p_home_stop) else $error("motor runs at home");
	property p_elec_stop; $rose(elecHomeAttained) |-> !motorRun; endproperty
	a_elec_stop: assert property (p_elec_stop) else $error("motor runs after move");
	property p_tmo_stop; $rose(homingTimeoutError) |-> !motorRun; endproperty
	a_tmo_stop: assert property (p_tmo_stop) else $error("motor runs after timeout");
	property p_load_home; posLoad |-> homeAttained; endproperty
	a_load_home: assert property (p_load_home) else $error("load without home");
	property p_load_pulse; posLoad |=> !posLoad; endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("load longer than a cycle");
	property p_accel_gate;
		$changed(homingAccelTime) |-> $past(regWrite) && $past(regAddr) == REG_ACCEL_TIME && $past(motorStopped);
	endproperty
	a_accel_gate: assert property (p_accel_gate) else $error("ramp time changed unasked");
	property p_accel_val; $changed(homingAccelTime) |-> {16'h0, homingAccelTime} == ($past(regWrData) & 32'hFFFF);
	endproperty
	a_accel_val: assert property (p_accel_val) else $error("ramp time wrong value");
	property p_servo_off; (!servoOnIn) [*5] |-> !motorRun; endproperty
	a_servo_off: assert property (p_servo_off) else $error("run with servo off");
	c_home: cover property ($rose(homeAttained));
	c_elec: cover property ($rose(elecHomeAttained));
	c_tmo: cover property ($rose(homingTimeoutError));
endmodule
bind shs_homing_sequencer shs_homing_sva chk_i (.*);

/* File: verif/shs_far_side.sv */
// Far side: motor and position, home and limit switches, encoder Z.
// Assumes the sequencer motion levels on clk_sys.
`timescale 1ns/1ps
module shs_far_side #(
	parameter int HOME_AT = 5000,
	parameter int LIM     = 100000
) (
	input  wire logic        clk_sys,
	input  wire logic        motorRun,
	input  wire logic        motorReverse,
	input  wire logic        motorFast,
	input  wire logic        posLoad,
	input  wire logic [31:0] posLoadValue,
	output logic             homeSwitchIn,
	output logic             zPulseIn,
	output logic             fwdLimitIn,
	output logic             revLimitIn,
	output logic             motorStopped,
	output logic [31:0]      absolutePositionValue
);
	logic signed [31:0] pos = 32'sh0;
	logic signed [31:0] step;
	// ==========
	// Motion
	assign step = motorFast ? 32'sh4 : 32'sh1;
	always @(posedge clk_sys)
		if (posLoad)
			pos <= posLoadValue;
		else if (motorRun)
			pos <= motorReverse ? pos - step : pos + step;
	// Switch far from start so the slow pass settles first
	assign homeSwitchIn = pos >= HOME_AT;
	// Z window eight counts wide: two samples even at fast speed
	assign zPulseIn = pos[5:0] >= 6'h20 && pos[5:0] < 6'h28;
	assign fwdLimitIn = pos >= LIM;
	assign revLimitIn = pos <= -LIM;
	assign motorStopped = !motorRun;
	assign absolutePositionValue = pos;
endmodule

/* File: verif/servo_homing_sequencer_tb.sv */
// Testbench of the homing sequencer with a far-side model.
// Assumes a 125 MHz clock and a shortened millisecond.
`timescale 1ns/1ps
module servo_homing_sequencer_tb;
	import shs_pkg::*;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [31:0] regWrData = 32'h0, regRdData, posLoadValue, absolutePositionValue, off, rdv, ev;
	logic        regWrite = 1'b0, regRead = 1'b0, homingTriggerIn = 1'b0, servoOnIn = 1'b0;
	logic        homeSwitchIn, zPulseIn, fwdLimitIn, revLimitIn, motorStopped, motorRun, motorReverse;
	logic        motorFast, posLoad, homeAttained, elecHomeAttained, homingTimeoutError, irq;
	logic [15:0] homingAccelTime;
	int          seed = 32'h5a06, error_cnt = 0, comparisons = 0;
	always #4 clk_sys = ~clk_sys;
	shs_homing_sequencer #(.CYC_PER_MS(10)) dut (.*);
	shs_far_side far (.*);
	// ==========
	// Tasks
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk_sys);
		regWrite <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(negedge clk_sys);
		d = regRdData;
		@(posedge clk_sys);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return homeAttained;
			1: return elecHomeAttained;
			2: return homingTimeoutError;
			3: return posLoad;
			default: return motorRun;
		endcase
	endfunction
	task automatic waitHi(input int s);
		int i;
		for (i = 0; i < 4000; i++) begin
			@(negedge clk_sys);
			if (sig(s) === 1'b1)
				break;
		end
		if (i == 4000) begin
			chk("wait level", 32'h0, 32'h1);
			finish_test();
		end
		@(posedge clk_sys);
	endtask
	function automatic logic [31:0] rstVal(input int a);
		return a == 3 ? 32'h3E8 : a == 4 ? 32'h2710 : 32'h0;
	endfunction
	// ==========
	// Scenarios
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (20) @(posedge clk_sys);
		for (int a = 0; a < 5; a++) begin
			rd(a[3:0], rdv);
			chk("reset value", rdv, rstVal(a));
		end
		rd(4'hF, rdv);
		chk("unmapped", rdv, 32'h0);
		servoOnIn <= 1'b1;
		wr(REG_ACCEL_TIME, 32'h1F4);
		chk("ramp time", {16'h0, homingAccelTime}, 32'h1F4);
		ev = $unsigned($random(seed)) % 10;
		wr(REG_MODE_SELECT, ev);
		rd(REG_MODE_SELECT, rdv);
		chk("mode", rdv, ev);
		for (int k = 0; k < 2; k++) begin
			off = $random(seed) & 32'hFF;
			wr(REG_HOME_OFFSET, off);
			wr(REG_OFFSET_LIMIT, k);
			ev = k ? absolutePositionValue + off : off;
			wr(REG_ENABLE_METHOD, {16'h0, METHOD_TAKE_POS});
			waitHi(3);
			chk("take position", posLoadValue, ev);
			rd(REG_ENABLE_METHOD, rdv);
			chk("method cleared", rdv, 32'h0);
		end
		wr(REG_OFFSET_LIMIT, 32'h2);
		wr(REG_MODE_SELECT, 32'h2);
		wr(REG_IRQ_STATUS, 32'hF);
		wr(REG_IRQ_MASK, 32'h1);
		wr(REG_ENABLE_METHOD, {16'h0, METHOD_TRIG_HOME});
		// Start on Z means a slow reverse back-off instead of a fast forward search
		rdv = zPulseIn;
		homingTriggerIn <= 1'b1;
		waitHi(4);
		chk("mode 2 motion", {motorFast, motorReverse}, rdv ? 32'h1 : 32'h2);
		homingTriggerIn <= 1'b0;
		waitHi(0);
		chk("z home value", posLoadValue, off);
		chk("irq set", irq, 1'b1);
		wr(REG_IRQ_STATUS, 32'h1);
		rd(REG_IRQ_STATUS, rdv);
		chk("status clear", rdv & 32'h1, 32'h0);
		chk("irq clear", irq, 1'b0);
		wr(REG_MODE_SELECT, 32'h3);
		rdv = zPulseIn;
		wr(REG_ENABLE_METHOD, {16'h0, METHOD_NOW});
		waitHi(4);
		chk("mode 3 motion", {motorFast, motorReverse}, rdv ? 32'h0 : 32'h3);
		waitHi(0);
		rd(REG_ENABLE_METHOD, rdv);
		chk("method now cleared", rdv, 32'h0);
		off = $random(seed) & 32'hFF;
		wr(REG_HOME_OFFSET, off);
		wr(REG_ENABLE_METHOD, {16'h0, METHOD_ELEC_NOW});
		waitHi(1);
		ev = absolutePositionValue - off;
		chk("elec stop", $signed(ev) < 8 && $signed(ev) > -8, 1'b1);
		wr(REG_DURATION_LIMIT, 32'h1);
		wr(REG_MODE_SELECT, 32'h0);
		wr(REG_ENABLE_METHOD, {16'h0, METHOD_NOW});
		waitHi(2);
		rd(REG_ENABLE_METHOD, rdv);
		chk("timeout method", rdv, 32'h0);
		rd(REG_IRQ_STATUS, rdv);
		chk("timeout status", rdv & 32'h4, 32'h4);
		// Second reset: power-on method must start a fast forward search on the first servo-on after it
		servoOnIn <= 1'b0;
		reset_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		wr(REG_ENABLE_METHOD, {16'h0, METHOD_POWER_ON});
		servoOnIn <= 1'b1;
		waitHi(4);
		chk("power-on search", {motorFast, motorReverse}, 32'h2);
		finish_test();
	end
endmodule
